// ---- verilog/rail_override_consts.vh ----
// Function
// - Bit 7 sets open-drain output four level.
// - Bits 6-4 set output three-one levels.
// - Bit 3 forces termination regulator on.
// - Bit 2 forces load switch B two on.
// - Bit 1 forces load switch B one on.
// - Bit 0 forces linear regulator A three on.
// - Override/output register resets to 89h.
// - Disable bit at 0 forces rail off.
// - Mask bit 7 masks linear A two fault.
// - Mask bit 6 masks switch A one fault.
// - Mask bits 5-0 mask step-down six-one faults.
// - Fault-mask register resets to C0h.
`ifndef RAIL_OVERRIDE_CONSTS_VH
`define RAIL_OVERRIDE_CONSTS_VH

`define OVERRIDE_REG_ADDR   8'h00A1
`define FAULT_MASK_REG_ADDR 8'h00A2
`define OVERRIDE_REG_RESET  8'h0089
`define FAULT_MASK_RESET    8'h00C0
`define UNMAPPED_READ_VALUE 8'h0000

`define LEVEL_FOUR_BIT      7
`define LEVEL_THREE_BIT     6
`define LEVEL_TWO_BIT       5
`define LEVEL_ONE_BIT       4
`define TERM_FORCE_BIT      3
`define SWB_TWO_FORCE_BIT   2
`define SWB_ONE_FORCE_BIT   1
`define LIN_A3_FORCE_BIT    0

`define SERIAL_ADDR_DEFAULT 7'h0042
`define BITS_PER_BYTE       4'h0008

`endif

// ---- verilog/rail_enable_gate.v ----
`timescale 1ns/1ps
module rail_enable_gate
(
  // Clock and reset
  input  wire clk_in,
  input  wire resetn_in,
  // Control terms
  input  wire force_on_in,
  input  wire pin_enable_in,
  input  wire disable_n_in,
  // Rail enable
  output reg  rail_on_out
);

  // A disable bit of 0 wins over both the override and the pin control.
  always @(posedge clk_in)
  begin
    if (!resetn_in)
      rail_on_out <= 1'b0;
    else
      rail_on_out <= disable_n_in & (force_on_in | pin_enable_in);
  end

endmodule

// ---- verilog/rail_override_fault_mask.v ----
`timescale 1ns/1ps
`include "rail_override_consts.vh"
module rail_override_fault_mask
#(
  parameter [6:0] DEVICE_ADDR = `SERIAL_ADDR_DEFAULT,
  // Bit n set: general output n+1 is push-pull, else open-drain.
  parameter [2:0] PUSH_PULL   = 3'h0
)
(
  // Clock and reset
  input  wire       clk_in,
  input  wire       resetn_in,
  // Serial control bus
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  // Rail control from pins or internal power-good sequencing
  input  wire       term_reg_pin_en_in,
  input  wire       switch_b_two_pin_en_in,
  input  wire       switch_b_one_pin_en_in,
  input  wire       linear_a_three_pin_en_in,
  // Disable bits, 0 forces the rail off
  input  wire       term_reg_disable_in,
  input  wire       switch_b_two_disable_in,
  input  wire       switch_b_one_disable_in,
  input  wire       linear_a_three_disable_in,
  // Rail enables
  output wire       termination_regulator_on_out,
  output wire       load_switch_b_two_on_out,
  output wire       load_switch_b_one_on_out,
  output wire       linear_reg_a_three_on_out,
  // General outputs
  output reg  [3:0] general_output_out,
  output reg  [3:0] general_output_oe_out,
  // Power faults: 7 linear A two, 6 switch A one, 5..0 step-down six..one
  input  wire [7:0] rail_fault_in,
  output reg        shutdown_request_out
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_AACK  = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_WACK  = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_RACK  = 3'h6;

  reg  [7:0] rail_override_and_output_level;
  reg  [7:0] rail_fault_shutdown_mask_one;
  reg  [2:0] state;
  reg  [7:0] shift;
  reg  [3:0] bit_count;
  reg  [7:0] pointer;
  reg        read_mode;
  reg        first_byte;
  reg        master_nack;
  reg        scl_q;
  reg        sda_q;
  reg        scl_prev;
  reg        sda_prev;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_seen;
  wire       stop_seen;
  wire [7:0] read_value;

  function [7:0] reg_read;
    input [7:0] addr;
    input [7:0] override_value;
    input [7:0] mask_value;
    begin
      if (addr == `OVERRIDE_REG_ADDR)
        reg_read = override_value;
      else if (addr == `FAULT_MASK_REG_ADDR)
        reg_read = mask_value;
      else
        reg_read = `UNMAPPED_READ_VALUE;
    end
  endfunction

  function [1:0] drive_pin;
    input level;
    input push_pull;
    begin
      // Result is {output value, output enable}.
      if (push_pull)
        drive_pin = {level, 1'b1};
      else
        drive_pin = {1'b0, ~level};
    end
  endfunction

  assign scl_rise   = scl_q & ~scl_prev;
  assign scl_fall   = ~scl_q & scl_prev;
  assign start_seen = scl_q & scl_prev & sda_prev & ~sda_q;
  assign stop_seen  = scl_q & scl_prev & ~sda_prev & sda_q;
  assign read_value = reg_read(pointer, rail_override_and_output_level,
                               rail_fault_shutdown_mask_one);

  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_q    <= scl_in;
      sda_q    <= sda_in;
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  // Serial slave: address, register pointer, then data with auto-increment.
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state                          <= ST_IDLE;
      shift                          <= 8'h0000;
      bit_count                      <= 4'h0000;
      pointer                        <= 8'h0000;
      read_mode                      <= 1'b0;
      first_byte                     <= 1'b0;
      master_nack                    <= 1'b0;
      sda_out                        <= 1'b0;
      sda_oe_out                     <= 1'b0;
      rail_override_and_output_level <= `OVERRIDE_REG_RESET;
      rail_fault_shutdown_mask_one   <= `FAULT_MASK_RESET;
    end
    else if (start_seen)
    begin
      state      <= ST_ADDR;
      bit_count  <= 4'h0000;
      sda_oe_out <= 1'b0;
    end
    else if (stop_seen)
    begin
      state      <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          sda_oe_out <= 1'b0;
        end
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            shift     <= {shift[6:0], sda_q};
            bit_count <= bit_count + 4'h0001;
          end
          else if (scl_fall && bit_count == `BITS_PER_BYTE)
          begin
            if (shift[7:1] == DEVICE_ADDR)
            begin
              read_mode  <= shift[0];
              sda_oe_out <= 1'b1;
              state      <= ST_AACK;
            end
            else
              state <= ST_IDLE;
          end
        end
        ST_AACK:
        begin
          if (scl_fall)
          begin
            bit_count  <= 4'h0000;
            first_byte <= 1'b1;
            if (read_mode)
            begin
              shift      <= read_value;
              sda_oe_out <= ~read_value[7];
              pointer    <= pointer + 8'h0001;
              state      <= ST_RDATA;
            end
            else
            begin
              sda_oe_out <= 1'b0;
              state      <= ST_WDATA;
            end
          end
        end
        ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift     <= {shift[6:0], sda_q};
            bit_count <= bit_count + 4'h0001;
          end
          else if (scl_fall && bit_count == `BITS_PER_BYTE)
          begin
            if (first_byte)
              pointer <= shift;
            else
            begin
              if (pointer == `OVERRIDE_REG_ADDR)
                rail_override_and_output_level <= shift;
              if (pointer == `FAULT_MASK_REG_ADDR)
                rail_fault_shutdown_mask_one <= shift;
              pointer <= pointer + 8'h0001;
            end
            sda_oe_out <= 1'b1;
            state      <= ST_WACK;
          end
        end
        ST_WACK:
        begin
          if (scl_fall)
          begin
            sda_oe_out <= 1'b0;
            bit_count  <= 4'h0000;
            first_byte <= 1'b0;
            state      <= ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
            bit_count <= bit_count + 4'h0001;
          else if (scl_fall)
          begin
            if (bit_count == `BITS_PER_BYTE)
            begin
              sda_oe_out <= 1'b0;
              state      <= ST_RACK;
            end
            else
            begin
              shift      <= {shift[6:0], 1'b0};
              sda_oe_out <= ~shift[6];
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
            master_nack <= sda_q;
          else if (scl_fall)
          begin
            bit_count <= 4'h0000;
            if (master_nack)
              state <= ST_IDLE;
            else
            begin
              shift      <= read_value;
              sda_oe_out <= ~read_value[7];
              pointer    <= pointer + 8'h0001;
              state      <= ST_RDATA;
            end
          end
        end
        default:
        begin
          state      <= ST_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // General output pins follow their level bits.
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      general_output_out    <= 4'h0000;
      general_output_oe_out <= 4'h0000;
    end
    else
    begin
      {general_output_out[3], general_output_oe_out[3]} <=
        drive_pin(rail_override_and_output_level[`LEVEL_FOUR_BIT], 1'b0);
      {general_output_out[2], general_output_oe_out[2]} <=
        drive_pin(rail_override_and_output_level[`LEVEL_THREE_BIT], PUSH_PULL[2]);
      {general_output_out[1], general_output_oe_out[1]} <=
        drive_pin(rail_override_and_output_level[`LEVEL_TWO_BIT], PUSH_PULL[1]);
      {general_output_out[0], general_output_oe_out[0]} <=
        drive_pin(rail_override_and_output_level[`LEVEL_ONE_BIT], PUSH_PULL[0]);
    end
  end

  // Any unmasked fault requests the shutdown sequence.
  always @(posedge clk_in)
  begin
    if (!resetn_in)
      shutdown_request_out <= 1'b0;
    else
      shutdown_request_out <= |(rail_fault_in &
                                ~rail_fault_shutdown_mask_one);
  end

  rail_enable_gate term_gate
  (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .force_on_in   (rail_override_and_output_level[`TERM_FORCE_BIT]),
    .pin_enable_in (term_reg_pin_en_in),
    .disable_n_in  (term_reg_disable_in),
    .rail_on_out   (termination_regulator_on_out)
  );

  rail_enable_gate swb_two_gate
  (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .force_on_in   (rail_override_and_output_level[`SWB_TWO_FORCE_BIT]),
    .pin_enable_in (switch_b_two_pin_en_in),
    .disable_n_in  (switch_b_two_disable_in),
    .rail_on_out   (load_switch_b_two_on_out)
  );

  rail_enable_gate swb_one_gate
  (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .force_on_in   (rail_override_and_output_level[`SWB_ONE_FORCE_BIT]),
    .pin_enable_in (switch_b_one_pin_en_in),
    .disable_n_in  (switch_b_one_disable_in),
    .rail_on_out   (load_switch_b_one_on_out)
  );

  rail_enable_gate lin_a3_gate
  (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .force_on_in   (rail_override_and_output_level[`LIN_A3_FORCE_BIT]),
    .pin_enable_in (linear_a_three_pin_en_in),
    .disable_n_in  (linear_a_three_disable_in),
    .rail_on_out   (linear_reg_a_three_on_out)
  );

endmodule

// ---- tb/rail_override_fault_mask_properties.sv ----
`timescale 1ns/1ps
module rail_override_fault_mask_properties
#(
  parameter [2:0] PUSH_PULL = 3'h0
)
(
  input wire       clk_in,
  input wire       resetn_in,
  input wire       term_reg_pin_en_in,
  input wire       switch_b_two_pin_en_in,
  input wire       switch_b_one_pin_en_in,
  input wire       linear_a_three_pin_en_in,
  input wire       term_reg_disable_in,
  input wire       switch_b_two_disable_in,
  input wire       switch_b_one_disable_in,
  input wire       linear_a_three_disable_in,
  input wire       termination_regulator_on_out,
  input wire       load_switch_b_two_on_out,
  input wire       load_switch_b_one_on_out,
  input wire       linear_reg_a_three_on_out,
  input wire [3:0] general_output_out,
  input wire [7:0] rail_fault_in,
  input wire       shutdown_request_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_release;
    $rose(resetn_in);
  endsequence
  sequence s_term_en;
    term_reg_disable_in && term_reg_pin_en_in;
  endsequence
  property p_release;
    s_release |-> !shutdown_request_out && !termination_regulator_on_out;
  endproperty
  a_release: assert property (p_release) else $error("outputs set at release");
  property p_term_off;
    !term_reg_disable_in |=> !termination_regulator_on_out;
  endproperty
  a_term_off: assert property (p_term_off) else $error("disabled rail on");
  property p_term_on;
    s_term_en |=> termination_regulator_on_out;
  endproperty
  a_term_on: assert property (p_term_on) else $error("term rail off");
  property p_load_switch_b_two_on;
    switch_b_two_disable_in && switch_b_two_pin_en_in |=> load_switch_b_two_on_out;
  endproperty
  a_load_switch_b_two_on: assert property (p_load_switch_b_two_on) else $error("switch b two off");
  property p_load_switch_b_one_on;
    switch_b_one_disable_in && switch_b_one_pin_en_in |=> load_switch_b_one_on_out;
  endproperty
  a_load_switch_b_one_on: assert property (p_load_switch_b_one_on) else $error("switch b one off");
  property p_lin_on;
    linear_a_three_disable_in && linear_a_three_pin_en_in |=> linear_reg_a_three_on_out;
  endproperty
  a_lin_on: assert property (p_lin_on) else $error("linear a three off");
  property p_shut_idle;
    rail_fault_in == 8'h00 |=> !shutdown_request_out;
  endproperty
  a_shut_idle: assert property (p_shut_idle) else $error("shutdown without fault");
  property p_od_four;
    general_output_out[3] == 1'b0;
  endproperty
  a_od_four: assert property (p_od_four) else $error("output four driven high");
  property p_od_low;
    (general_output_out[2:0] & ~PUSH_PULL) == 3'h0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain driven high");
endmodule
bind rail_override_fault_mask rail_override_fault_mask_properties #(.PUSH_PULL(PUSH_PULL)) u_props
(
  .clk_in(clk_in), .resetn_in(resetn_in), .term_reg_pin_en_in(term_reg_pin_en_in),
  .switch_b_two_pin_en_in(switch_b_two_pin_en_in),
  .switch_b_one_pin_en_in(switch_b_one_pin_en_in),
  .linear_a_three_pin_en_in(linear_a_three_pin_en_in), .term_reg_disable_in(term_reg_disable_in),
  .switch_b_two_disable_in(switch_b_two_disable_in),
  .switch_b_one_disable_in(switch_b_one_disable_in),
  .linear_a_three_disable_in(linear_a_three_disable_in),
  .termination_regulator_on_out(termination_regulator_on_out),
  .load_switch_b_two_on_out(load_switch_b_two_on_out),
  .load_switch_b_one_on_out(load_switch_b_one_on_out),
  .linear_reg_a_three_on_out(linear_reg_a_three_on_out),
  .general_output_out(general_output_out), .rail_fault_in(rail_fault_in),
  .shutdown_request_out(shutdown_request_out)
);

// ---- tb/rail_override_fault_mask_tb.sv ----
`timescale 1ns/1ps
`include "rail_override_consts.vh"
module rail_override_fault_mask_tb;
  typedef struct {string n; logic [7:0] v;} note_t;
  logic       clk_in = 0;
  logic       resetn_in = 0;
  logic       scl = 1;
  logic       sda = 1;
  wire        sda_in;
  wire        sda_oe;
  wire        sda_o;
  wire        shut;
  wire  [3:0] rail;
  wire  [3:0] gen;
  wire  [3:0] gen_oe;
  logic [3:0] pin_en = 0;
  logic [3:0] dis = 4'hf;
  logic [7:0] fault = 0;
  logic [7:0] r;
  logic [7:0] m;
  logic [7:0] q;
  logic [7:0] got_v;
  logic       ack;
  note_t      e;
  note_t      exp_q[$];
  event       seen_ev;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  // While enabled the device puts its data value on the pulled-up shared line.
  assign sda_in = sda & (~sda_oe | sda_o);
  rail_override_fault_mask u_rail_override_fault_mask
  (
    .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .term_reg_pin_en_in(pin_en[3]), .switch_b_two_pin_en_in(pin_en[2]),
    .switch_b_one_pin_en_in(pin_en[1]), .linear_a_three_pin_en_in(pin_en[0]),
    .term_reg_disable_in(dis[3]), .switch_b_two_disable_in(dis[2]),
    .switch_b_one_disable_in(dis[1]), .linear_a_three_disable_in(dis[0]),
    .termination_regulator_on_out(rail[3]), .load_switch_b_two_on_out(rail[2]),
    .load_switch_b_one_on_out(rail[1]), .linear_reg_a_three_on_out(rail[0]),
    .general_output_out(gen), .general_output_oe_out(gen_oe), .rail_fault_in(fault),
    .shutdown_request_out(shut)
  );
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial
    forever
    begin
      @(seen_ev);
      e = exp_q.pop_front();
      samples_checked++;
      if (e.v !== got_v)
      begin
        $display("unexpected %s: expected %h seen %h", e.n, e.v, got_v);
        error_cnt++;
      end
    end
  task tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task expect_v(input string n, input logic [7:0] x, input logic [7:0] v);
    exp_q.push_back('{n, x});
    got_v = v;
    -> seen_ev;
    #1;
  endtask
  task bit_io(input logic b, output logic s);
    sda <= b;
    tick(4);
    scl <= 1;
    tick(4);
    s = sda_in;
    scl <= 0;
    tick(4);
  endtask
  task byte_io(input [7:0] d, input logic mack, output [7:0] o, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], o[i]);
    bit_io(mack, a);
  endtask
  task start;
    sda <= 1;
    tick(4);
    scl <= 1;
    tick(4);
    sda <= 0;
    tick(4);
    scl <= 0;
    tick(4);
  endtask
  task stop;
    sda <= 0;
    tick(4);
    scl <= 1;
    tick(4);
    sda <= 1;
    tick(4);
  endtask
  task write_reg(input [7:0] a, input [7:0] d);
    start;
    byte_io({`SERIAL_ADDR_DEFAULT, 1'b0}, 1, q, ack);
    byte_io(a, 1, q, ack);
    byte_io(d, 1, q, ack);
    expect_v("data ack", 8'h00, {7'h00, ack});
    stop;
  endtask
  task read2(input [7:0] a, input [7:0] x0, input [7:0] x1);
    start;
    byte_io({`SERIAL_ADDR_DEFAULT, 1'b0}, 1, q, ack);
    byte_io(a, 1, q, ack);
    start;
    byte_io({`SERIAL_ADDR_DEFAULT, 1'b1}, 1, q, ack);
    byte_io(8'hff, 0, q, ack);
    expect_v("first byte", x0, q);
    byte_io(8'hff, 1, q, ack);
    expect_v("second byte", x1, q);
    stop;
  endtask
  task check_outs(input [7:0] ov, input [7:0] mv);
    tick(3);
    expect_v("rails", {4'h0, dis & (ov[3:0] | pin_en)}, {4'h0, rail});
    expect_v("output enables", {4'h0, ~ov[7:4]}, {4'h0, gen_oe});
    expect_v("output levels", 8'h00, {4'h0, gen});
    expect_v("shutdown", {7'h00, |(fault & ~mv)}, {7'h00, shut});
  endtask
  task tally_and_finish;
    $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    void'($urandom(17579));
    tick(6);
    resetn_in <= 1;
    tick(2);
    read2(`OVERRIDE_REG_ADDR, `OVERRIDE_REG_RESET, `FAULT_MASK_RESET);
    check_outs(`OVERRIDE_REG_RESET, `FAULT_MASK_RESET);
    for (int k = 0; k < 6; k++)
    begin
      r = 8'($urandom);
      m = 8'($urandom);
      write_reg(`OVERRIDE_REG_ADDR, r);
      write_reg(`FAULT_MASK_REG_ADDR, m);
      pin_en <= 4'($urandom);
      dis <= 4'($urandom);
      fault <= 8'($urandom);
      check_outs(r, m);
      read2(`OVERRIDE_REG_ADDR, r, m);
    end
    write_reg(8'ha3, 8'h5a);
    read2(8'ha3, `UNMAPPED_READ_VALUE, `UNMAPPED_READ_VALUE);
    start;
    byte_io({`SERIAL_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1, q, ack);
    expect_v("foreign address ack", 8'h01, {7'h00, ack});
    stop;
    resetn_in <= 0;
    tick(2);
    resetn_in <= 1;
    tick(2);
    read2(`OVERRIDE_REG_ADDR, `OVERRIDE_REG_RESET, `FAULT_MASK_RESET);
    check_outs(`OVERRIDE_REG_RESET, `FAULT_MASK_RESET);
    tally_and_finish;
  end
endmodule
